// *** rtl/pwc_pkg.sv ***
// Package of register offsets, field layouts and reset values for the duty pair combine block.
`default_nettype none
package pwc_pkg;
  localparam int          ADDR_W            = 8;   // Byte address width of the register window.
  localparam int          DUTY_W            = 12;  // Width of the duty value field.
  localparam int          DUTY_LSB          = 0;   // Low bit of the duty field.
  localparam int          CHAN_MAX          = 128; // Largest channel count the map supports.
  localparam logic [7:0]  OFF_BCAST_DUTY    = 8'h04; // Broadcast duty, write only.
  localparam logic [7:0]  OFF_COMBINE_LOW   = 8'h3C; // Pair combine, channels 63 to 0.
  localparam logic [7:0]  OFF_COMBINE_STEP  = 8'h10; // Spacing of combine registers.
  localparam logic [7:0]  OFF_COMBINE_HIGH  = 8'h4C; // Pair combine, channels 127 to 64.
  localparam logic [7:0]  OFF_SELECT_BASE   = 8'h80; // Channel select words, four of them.
  localparam logic [7:0]  OFF_SELECT_LAST   = 8'h8C; // Last channel select word.
  localparam logic [7:0]  OFF_DUTY_BASE     = 8'hC0; // Read only duty of channel at index.
  localparam logic [7:0]  OFF_DUTY_INDEX    = 8'hC4; // Channel index for the duty readback.
  localparam logic [31:0] RESET_COMBINE     = 32'h0000_0000; // Reset value of combine regs.
  localparam logic [31:0] RESET_SELECT      = 32'h0000_0000; // Reset value of select regs.
  localparam logic [11:0] RESET_DUTY        = 12'h000; // Reset duty, channel disabled.
endpackage
`default_nettype wire

// *** rtl/pwc_pair_combine.sv ***
// Output stage that combines one even and odd waveform pair.
`default_nettype none
module pwc_pair_combine
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic combineEn,
  input  wire logic waveEven,
  input  wire logic waveOdd,
  output var  logic outEven,
  output var  logic outOdd
);
  // Exclusive-OR of the two waveforms of the pair.
  wire logic pairXor;
  wire logic evenNext;
  wire logic oddNext;

  assign pairXor  = waveEven ^ waveOdd;
  assign evenNext = combineEn ? pairXor : waveEven;
  assign oddNext  = combineEn ? ~pairXor : waveOdd;

  // Registers the pair outputs so each leaves from a flip-flop.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      outEven <= 1'b0;
      outOdd  <= 1'b0;
    end
    else
    begin
      outEven <= evenNext;
      outOdd  <= oddNext;
    end
  end

  // The even output follows the XOR one cycle after the inputs when combined.
  property p_pair_xor;
    @(posedge clk) disable iff (reset)
      combineEn |=> (outEven == $past(pairXor)) && (outOdd == !outEven);
  endproperty
  a_pair_xor: assert property (p_pair_xor) else $error("pair combine output wrong");

  // A cleared combine bit passes both waveforms unchanged.
  property p_pair_pass;
    @(posedge clk) disable iff (reset)
      !combineEn |=> (outEven == $past(waveEven)) && (outOdd == $past(waveOdd));
  endproperty
  a_pair_pass: assert property (p_pair_pass) else $error("pair pass through wrong");
endmodule
`default_nettype wire

// *** rtl/pwc_duty_combine.sv ***
// Broadcast duty loader and pair combine stage of a multi-channel modulator, APB slave.
//
// The APB interface to the registers was decided locally.
`default_nettype none
module pwc_duty_combine
#(
  parameter int NUM_CH = 128 // Channel count, even, at most 128.
)
(
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [pwc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output var  logic [31:0]               prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  input  wire logic [NUM_CH-1:0]         chanWave,
  output var  logic [NUM_CH-1:0]         chanEnable,
  output var  logic [NUM_CH-1:0]         pwmOut
);
  localparam int NUM_PAIR = NUM_CH / 2;  // Number of output pairs.
  localparam int NUM_SEL  = (NUM_CH + 31) / 32; // Select words in use.

  // Per channel duty storage.
  logic [pwc_pkg::DUTY_W-1:0] dutyMem_reg [NUM_CH];
  // Combine bits, one per pair, both registers joined.
  logic [63:0]                combine_reg;
  // Channel select bits for the broadcast load.
  logic [pwc_pkg::CHAN_MAX-1:0] select_reg;
  // Channel index for duty readback.
  logic [6:0]                 dutyIndex_reg;
  // Channel waveforms, synchronised through two flip-flops.
  logic [NUM_CH-1:0]          waveMeta_reg;
  logic [NUM_CH-1:0]          waveSync_reg;

  // Access phase strobes, address decodes and data of the bus.
  wire logic        accessWr;
  wire logic        accessRd;
  wire logic        hitDuty;
  wire logic        hitCombLow;
  wire logic        hitCombHigh;
  wire logic        hitSelect;
  wire logic        hitDutyRd;
  wire logic        hitIndex;
  wire logic        hitAny;
  wire logic [1:0]  selWord;
  wire logic [11:0] newDuty;
  wire logic        bcastLoad;
  logic [31:0]      readData;

  // Word select inside the channel select block.
  assign selWord   = paddr[3:2];
  assign accessWr  = psel && penable && pwrite;
  assign accessRd  = psel && penable && !pwrite;
  // Upper bits of the written word are dropped here.
  assign newDuty   = pwdata[pwc_pkg::DUTY_LSB +: pwc_pkg::DUTY_W];

  // Address decoding of the register window.
  assign hitDuty     = (paddr == pwc_pkg::OFF_BCAST_DUTY);
  assign hitCombLow  = (paddr == pwc_pkg::OFF_COMBINE_LOW);
  assign hitCombHigh = (paddr == pwc_pkg::OFF_COMBINE_HIGH) && (NUM_CH > 64);
  assign hitSelect   = (paddr >= pwc_pkg::OFF_SELECT_BASE) && (paddr <= pwc_pkg::OFF_SELECT_LAST)
                       && (paddr[1:0] == 2'b00) && (int'(selWord) < NUM_SEL);
  assign hitDutyRd   = (paddr == pwc_pkg::OFF_DUTY_BASE);
  assign hitIndex    = (paddr == pwc_pkg::OFF_DUTY_INDEX);
  assign hitAny      = hitDuty || hitCombLow || hitCombHigh || hitSelect || hitDutyRd
                       || hitIndex;
  assign bcastLoad   = accessWr && hitDuty;

  // Read multiplexer; the broadcast register and unmapped words read zero.
  always_comb
  begin
    readData = 32'h0000_0000;
    if (hitCombLow)
    begin
      readData = combine_reg[31:0];
    end
    else if (hitCombHigh)
    begin
      readData = combine_reg[63:32];
    end
    else if (hitSelect)
    begin
      readData = select_reg[32*selWord +: 32];
    end
    else if (hitDutyRd)
    begin
      if (int'(dutyIndex_reg) < NUM_CH)
      begin
        readData = {20'h0_0000, dutyMem_reg[dutyIndex_reg]};
      end
    end
    else if (hitIndex)
    begin
      readData = {25'h000_0000, dutyIndex_reg};
    end
  end

  // Bus answer: zero wait states, error on unmapped addresses.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hitAny;
      prdata  <= (psel && !penable && !pwrite) ? readData : 32'h0000_0000;
    end
  end

  // Control registers written by software.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      combine_reg   <= {pwc_pkg::RESET_COMBINE, pwc_pkg::RESET_COMBINE};
      select_reg    <= {4{pwc_pkg::RESET_SELECT}};
      dutyIndex_reg <= 7'h00;
    end
    else if (accessWr && pready)
    begin
      if (hitCombLow)
      begin
        combine_reg[31:0] <= pwdata;
      end
      else if (hitCombHigh)
      begin
        combine_reg[63:32] <= pwdata;
      end
      else if (hitSelect)
      begin
        select_reg[32*selWord +: 32] <= pwdata;
      end
      else if (hitIndex)
      begin
        dutyIndex_reg <= pwdata[6:0];
      end
    end
  end

  // Broadcast load of the duty store, all selected channels at one edge.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        dutyMem_reg[i] <= pwc_pkg::RESET_DUTY;
      end
    end
    else if (bcastLoad && pready)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (select_reg[i])
        begin
          dutyMem_reg[i] <= newDuty;
        end
      end
    end
  end

  // Enable flags and waveform synchroniser.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      chanEnable   <= '0;
      waveMeta_reg <= '0;
      waveSync_reg <= '0;
    end
    else
    begin
      waveMeta_reg <= chanWave;
      waveSync_reg <= waveMeta_reg;
      for (int i = 0; i < NUM_CH; i++)
      begin
        chanEnable[i] <= (dutyMem_reg[i] != 12'h000);
      end
    end
  end

  // Gated waveform: a disabled channel is forced low.
  wire logic [NUM_CH-1:0] gatedWave;
  assign gatedWave = waveSync_reg & chanEnable;

  // One combine stage per pair; bit n serves channels 2n and 2n+1.
  for (genvar n = 0; n < NUM_PAIR; n++)
  begin : g_pair
    pwc_pair_combine u_pair
    (
      .clk       (clk),
      .reset     (reset),
      .combineEn (combine_reg[n]),
      .waveEven  (gatedWave[2*n]),
      .waveOdd   (gatedWave[2*n+1]),
      .outEven   (pwmOut[2*n]),
      .outOdd    (pwmOut[2*n+1])
    );
  end

  // A broadcast write changes channel 0 duty when it is selected and leaves channel 1 alone when it is not.
  property p_bcast_load;
    @(posedge clk) disable iff (reset)
      (bcastLoad && pready && select_reg[0]) |=> (dutyMem_reg[0] == $past(newDuty));
  endproperty
  a_bcast_load: assert property (p_bcast_load) else $error("broadcast load missed");

  property p_bcast_keep;
    @(posedge clk) disable iff (reset)
      (bcastLoad && pready && !select_reg[1]) |=> $stable(dutyMem_reg[1]);
  endproperty
  a_bcast_keep: assert property (p_bcast_keep) else $error("unselected duty changed");

  // Zero duty keeps channel 0 disabled and its waveform low.
  property p_zero_low;
    @(posedge clk) disable iff (reset)
      (dutyMem_reg[0] == 12'h000) |=> !chanEnable[0] ##0 !gatedWave[0];
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("zero duty not disabled");

  // The broadcast register reads as zero.
  property p_duty_rd_zero;
    @(posedge clk) disable iff (reset)
      (psel && !penable && !pwrite && hitDuty) |=> (prdata == 32'h0000_0000) && pready;
  endproperty
  a_duty_rd_zero: assert property (p_duty_rd_zero) else $error("duty read not zero");

  // A write to the second combine word lands in the upper pairs.
  property p_comb_high;
    @(posedge clk) disable iff (reset)
      (accessWr && pready && hitCombHigh) |=> (combine_reg[63:32] == $past(pwdata));
  endproperty
  a_comb_high: assert property (p_comb_high) else $error("upper combine not written");

  // Pair zero is combined two cycles after combine bit 0 with stable waves.
  property p_pair0;
    @(posedge clk) disable iff (reset)
      combine_reg[0] ##1 combine_reg[0] |=>
        (pwmOut[0] == ($past(gatedWave[0], 1) ^ $past(gatedWave[1], 1)));
  endproperty
  a_pair0: assert property (p_pair0) else $error("pair zero not combined");
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the broadcast duty loader and pair combine block.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk = 1'b0;     // System clock, 100 ns period.
  logic         reset = 1'b1;   // Asynchronous reset, active high.
  logic         psel = 1'b0;    // Bus select.
  logic         penable = 1'b0; // Bus access phase.
  logic         pwrite = 1'b0;  // Bus direction.
  logic [7:0]   paddr = 8'h00;  // Bus byte address.
  logic [31:0]  pwdata = 32'h0; // Bus write data.
  logic [31:0]  prdata;         // Bus read data.
  logic         pready;         // Bus completion.
  logic         pslverr;        // Bus error flag.
  logic [127:0] chanWave = '0;  // Waveforms from the channel counters.
  logic [127:0] chanEnable;     // Channel enable flags.
  logic [127:0] pwmOut;         // Pair outputs.
  logic [31:0]  rd;             // Last read data.
  logic         er;             // Last error flag.
  int           fails = 0;      // Mismatch count.
  int           checks_done = 0; // Comparison count.
  int           cycles = 0;     // Cycle count for the hang limit.

  pwc_duty_combine #(.NUM_CH(128)) uut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chanWave(chanWave), .chanEnable(chanEnable),
    .pwmOut(pwmOut));

  // Clock generator.
  always #50 clk = ~clk;

  // Hang limit; a stuck run is reported as a failure.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      results();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Compares one value against its expectation.
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus transfer; holds the request until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Ends when pready is seen high; only the bench's hang limit ends it if pready never comes.
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads the stored duty of one channel through the index register.
  task automatic duty_of(input logic [7:0] ch, input logic [11:0] exp);
    apb(1'b1, 8'hC4, {24'h0, ch});
    apb(1'b0, 8'hC0, 32'h0);
    chk(rd, {20'h0, exp});
  endtask

  // Reset values, write-only readback and an unmapped address.
  task automatic t_regs();
    apb(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h4C, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h3C, 32'hA5A5_5A5A);
    apb(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'hA5A5_5A5A);
    apb(1'b1, 8'h3C, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk({er, rd}, 33'h0);
    apb(1'b0, 8'h50, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
  endtask

  // Broadcast reaches only selected channels; upper bits are dropped.
  task automatic t_bcast();
    apb(1'b1, 8'h80, 32'h21);
    apb(1'b0, 8'h80, 32'h0);
    chk({er, rd}, 33'h21);
    apb(1'b1, 8'h04, 32'hFFFF_FABC);
    duty_of(8'h00, 12'hABC);
    duty_of(8'h05, 12'hABC);
    duty_of(8'h01, 12'h000);
    apb(1'b0, 8'hC4, 32'h0);
    chk(rd, 32'h1);
    chk(chanEnable, 128'h21);
  endtask

  // Zero duty disables the channel and holds its output low.
  task automatic t_zero();
    chanWave <= 128'h21;
    apb(1'b1, 8'h80, 32'h20);
    apb(1'b1, 8'h04, 32'h0);
    repeat (5) @(posedge clk);
    chk(chanEnable, 128'h1);
    chk(pwmOut, 128'h1);
    duty_of(8'h00, 12'hABC);
  endtask

  // Pair combine in both registers, then a cleared bit passes waves.
  task automatic t_comb();
    chanWave <= 128'h7;
    apb(1'b1, 8'h80, 32'hF);
    apb(1'b1, 8'h88, 32'h3);
    apb(1'b1, 8'h04, 32'h123);
    apb(1'b1, 8'h3C, 32'h1);
    apb(1'b1, 8'h4C, 32'h1);
    repeat (5) @(posedge clk);
    chk(pwmOut, {62'h0, 2'b10, 60'h0, 4'h6});
    apb(1'b1, 8'h3C, 32'h0);
    repeat (5) @(posedge clk);
    chk(pwmOut[3:0], 4'h7);
  endtask

  // Main sequence.
  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_bcast();
    t_zero();
    t_comb();
    results();
  end
endmodule
`default_nettype wire
